// file: rtl/fcs_host.sv
// host-side controller that drives the flash command and status pins
// assumes flash pins sampled synchronously to ref_clk, one command at a time
`timescale 1ns/1ns
module fcs_host (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic cmd_valid,
	input wire logic [2:0] cmd_op,
	input wire logic [18:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_fail,
	output logic [18:0] fl_addr,
	output logic [7:0] fl_dq_out,
	output logic fl_dq_oe_n,
	input wire logic [7:0] fl_dq_in,
	output logic fl_ce_n,
	output logic fl_we_n,
	output logic fl_oe_n
);
	typedef enum logic [2:0] {
		S_IDLE, S_WR_SU, S_WR_LO, S_WR_HI, S_RD_LO, S_RD_HI, S_RESP
	} fcs_state_t;

	fcs_state_t state_r;
	logic [2:0] op_r;
	logic [2:0] step_r;
	logic [18:0] addr_r;
	logic [7:0] data_r;
	logic [4:0] cnt_r;
	logic polling_r;
	logic final_rd_r;
	logic first_rd_r;
	logic prev_tog_r;
	logic fail_seen_r;
	logic fail_r;
	logic [26:0] word;
	logic [2:0] len;

	function automatic logic [2:0] seq_len(input logic [2:0] op);
		case (op)
			fcs_pkg::OP_READ: seq_len = fcs_pkg::LEN_NONE;
			fcs_pkg::OP_ID_READ: seq_len = fcs_pkg::LEN_ID;
			fcs_pkg::OP_PROGRAM: seq_len = fcs_pkg::LEN_PROGRAM;
			fcs_pkg::OP_CHIP_ERASE: seq_len = fcs_pkg::LEN_ERASE;
			fcs_pkg::OP_SECTOR_ERASE: seq_len = fcs_pkg::LEN_ERASE;
			default: seq_len = fcs_pkg::LEN_SINGLE;
		endcase
	endfunction

	// address and data of one write step of a command sequence
	function automatic logic [26:0] seq_word(input logic [2:0] op,
		input logic [2:0] step, input logic [18:0] a, input logic [7:0] d);
		logic [26:0] u1;
		logic [26:0] u2;
		logic [26:0] cm;
		u1 = {fcs_pkg::A_UNLOCK1, fcs_pkg::D_UNLOCK1};
		u2 = {fcs_pkg::A_UNLOCK2, fcs_pkg::D_UNLOCK2};
		cm = {fcs_pkg::A_ANY, fcs_pkg::D_RESET};
		case (op)
			fcs_pkg::OP_SUSPEND: cm = {fcs_pkg::A_ANY, fcs_pkg::D_SUSPEND};
			fcs_pkg::OP_RESUME: cm = {fcs_pkg::A_ANY, fcs_pkg::D_RESUME};
			fcs_pkg::OP_ID_READ: begin
				if (step == 3'h2)
					cm = {fcs_pkg::A_UNLOCK1, fcs_pkg::D_ID};
				else
					cm = (step == 3'h0) ? u1 : u2;
			end
			fcs_pkg::OP_PROGRAM: begin
				if (step == 3'h2)
					cm = {fcs_pkg::A_UNLOCK1, fcs_pkg::D_PROGRAM};
				else if (step == 3'h3)
					cm = {a, d};
				else
					cm = (step == 3'h0) ? u1 : u2;
			end
			fcs_pkg::OP_CHIP_ERASE, fcs_pkg::OP_SECTOR_ERASE: begin
				if (step == 3'h2)
					cm = {fcs_pkg::A_UNLOCK1, fcs_pkg::D_ERASE_SETUP};
				else if (step == 3'h5 && op == fcs_pkg::OP_CHIP_ERASE)
					cm = {fcs_pkg::A_UNLOCK1, fcs_pkg::D_CHIP_ERASE};
				else if (step == 3'h5)
					cm = {a & fcs_pkg::A_SECTOR_MASK,
						fcs_pkg::D_SECTOR_ERASE};
				else
					cm = (step == 3'h0 || step == 3'h3) ? u1 : u2;
			end
			default: cm = {fcs_pkg::A_ANY, fcs_pkg::D_RESET};
		endcase
		seq_word = cm;
	endfunction

	always_comb begin
		word = seq_word(op_r, step_r, addr_r, data_r);
		len = seq_len(op_r);
	end

	// sequencer; only a single command is in flight, so nothing overlaps
	// a running program or erase
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= S_IDLE;
			op_r <= fcs_pkg::OP_READ;
			step_r <= 3'h0;
			addr_r <= 19'h00000;
			data_r <= 8'h00;
			cnt_r <= 5'h00;
			polling_r <= 1'b0;
			final_rd_r <= 1'b0;
			first_rd_r <= 1'b0;
			prev_tog_r <= 1'b0;
			fail_seen_r <= 1'b0;
			fail_r <= 1'b0;
		end else if (clk_en) begin
			case (state_r)
				S_IDLE: begin
					if (cmd_valid) begin
						op_r <= cmd_op;
						addr_r <= cmd_addr;
						data_r <= cmd_data;
						step_r <= 3'h0;
						cnt_r <= 5'h00;
						polling_r <= 1'b0;
						final_rd_r <= 1'b0;
						first_rd_r <= 1'b1;
						fail_seen_r <= 1'b0;
						fail_r <= 1'b0;
						if (seq_len(cmd_op) == fcs_pkg::LEN_NONE)
							state_r <= S_RD_LO;
						else
							state_r <= S_WR_SU;
					end
				end
				S_WR_SU: begin
					if (cnt_r == 5'(fcs_pkg::SETUP_CYC - 1)) begin
						cnt_r <= 5'h00;
						state_r <= S_WR_LO;
					end else
						cnt_r <= cnt_r + 5'h01;
				end
				S_WR_LO: begin
					if (cnt_r == 5'(fcs_pkg::WE_LOW_CYC - 1)) begin
						cnt_r <= 5'h00;
						state_r <= S_WR_HI;
					end else
						cnt_r <= cnt_r + 5'h01;
				end
				S_WR_HI: begin
					// data stays on the bus through this gap
					if (cnt_r == 5'(fcs_pkg::WE_HIGH_CYC - 1)) begin
						cnt_r <= 5'h00;
						if (step_r + 3'h1 < len) begin
							step_r <= step_r + 3'h1;
							state_r <= S_WR_SU;
						end else if (fail_r || op_r == fcs_pkg::OP_RESET ||
							op_r == fcs_pkg::OP_SUSPEND ||
							op_r == fcs_pkg::OP_RESUME)
							state_r <= S_RESP;
						else begin
							// poll only after the last strobe has risen
							polling_r <= op_r != fcs_pkg::OP_ID_READ;
							state_r <= S_RD_LO;
						end
					end else
						cnt_r <= cnt_r + 5'h01;
				end
				S_RD_LO: begin
					if (cnt_r == 5'(fcs_pkg::ACCESS_CYC - 1)) begin
						cnt_r <= 5'h00;
						state_r <= S_RD_HI;
					end else
						cnt_r <= cnt_r + 5'h01;
				end
				S_RD_HI: begin
					// strobes released so each poll is a distinct read
					if (cnt_r == 5'(fcs_pkg::RECOVER_CYC - 1)) begin
						cnt_r <= 5'h00;
						state_r <= S_RESP;
						if (polling_r) begin
							state_r <= S_RD_LO;
							first_rd_r <= 1'b0;
							prev_tog_r <= data_r[fcs_pkg::BIT_TOGGLE];
							if (!first_rd_r &&
								data_r[fcs_pkg::BIT_TOGGLE] == prev_tog_r) begin
								polling_r <= 1'b0;
								final_rd_r <= 1'b1;
							end else if (!first_rd_r && fail_seen_r) begin
								fail_r <= 1'b1;
								op_r <= fcs_pkg::OP_RESET;
								step_r <= 3'h0;
								polling_r <= 1'b0;
								state_r <= S_WR_SU;
							end else if (data_r[fcs_pkg::BIT_FAIL])
								fail_seen_r <= 1'b1;
						end
					end else
						cnt_r <= cnt_r + 5'h01;
				end
				S_RESP: state_r <= S_IDLE;
				default: state_r <= S_IDLE;
			endcase
			if (state_r == S_RD_LO && cnt_r == 5'(fcs_pkg::ACCESS_CYC - 1))
				data_r <= fl_dq_in;
		end
	end

	// pin drivers, all registered
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fl_addr <= 19'h00000;
			fl_dq_out <= 8'h00;
			fl_dq_oe_n <= 1'b1;
			fl_ce_n <= 1'b1;
			fl_we_n <= 1'b1;
			fl_oe_n <= 1'b1;
		end else if (clk_en) begin
			fl_we_n <= !(state_r == S_WR_LO);
			fl_oe_n <= !(state_r == S_RD_LO);
			fl_ce_n <= !(state_r == S_WR_SU || state_r == S_WR_LO ||
				state_r == S_WR_HI || state_r == S_RD_LO);
			fl_dq_oe_n <= !(state_r == S_WR_SU || state_r == S_WR_LO ||
				state_r == S_WR_HI);
			if (state_r == S_WR_SU || state_r == S_WR_LO || state_r == S_WR_HI) begin
				fl_addr <= word[26:8];
				fl_dq_out <= word[7:0];
			end else if (state_r == S_RD_LO || state_r == S_RD_HI)
				fl_addr <= addr_r;
		end
	end

	// user-side answer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			rsp_fail <= 1'b0;
		end else if (clk_en) begin
			cmd_ready <= state_r == S_IDLE && !cmd_valid;
			rsp_valid <= state_r == S_RESP;
			if (state_r == S_RESP) begin
				rsp_data <= data_r;
				rsp_fail <= fail_r;
			end
		end
	end
endmodule // fcs_host

// file: rtl/fcs_pkg.sv
// constants shared by the flash command sequencer host
// assumes a byte-wide flash with 19 address bits on the far side
package fcs_pkg;
	localparam int ADDR_W = 19;
	localparam int DATA_W = 8;
	// user command codes
	localparam logic [2:0] OP_READ = 3'h0;
	localparam logic [2:0] OP_RESET = 3'h1;
	localparam logic [2:0] OP_PROGRAM = 3'h2;
	localparam logic [2:0] OP_CHIP_ERASE = 3'h3;
	localparam logic [2:0] OP_SECTOR_ERASE = 3'h4;
	localparam logic [2:0] OP_SUSPEND = 3'h5;
	localparam logic [2:0] OP_RESUME = 3'h6;
	localparam logic [2:0] OP_ID_READ = 3'h7;
	// unlock and command cycle addresses, upper bits driven zero except the sector bits of the sector erase cycle
	localparam logic [18:0] A_UNLOCK1 = 19'h00555;
	localparam logic [18:0] A_UNLOCK2 = 19'h002aa;
	localparam logic [18:0] A_ANY = 19'h00000;
	localparam logic [18:0] A_SECTOR_MASK = 19'h70000;
	localparam logic [7:0] D_UNLOCK1 = 8'haa;
	localparam logic [7:0] D_UNLOCK2 = 8'h55;
	localparam logic [7:0] D_ID = 8'h90;
	localparam logic [7:0] D_PROGRAM = 8'ha0;
	localparam logic [7:0] D_ERASE_SETUP = 8'h80;
	localparam logic [7:0] D_CHIP_ERASE = 8'h10;
	localparam logic [7:0] D_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] D_SUSPEND = 8'hb0;
	localparam logic [7:0] D_RESUME = 8'h30;
	localparam logic [7:0] D_RESET = 8'hf0;
	// sequence lengths in write cycles
	localparam logic [2:0] LEN_NONE = 3'h0;
	localparam logic [2:0] LEN_SINGLE = 3'h1;
	localparam logic [2:0] LEN_ID = 3'h3;
	localparam logic [2:0] LEN_PROGRAM = 3'h4;
	localparam logic [2:0] LEN_ERASE = 3'h6;
	// status bit positions on the data bus
	localparam int BIT_POLL = 7;
	localparam int BIT_TOGGLE = 6;
	localparam int BIT_FAIL = 5;
	// bus timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_SETUP_NS = 8;
	localparam int T_WE_LOW_NS = 40;
	localparam int T_WE_HIGH_NS = 24;
	localparam int T_ACCESS_NS = 90;
	localparam int T_RECOVER_NS = 24;
	localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WE_LOW_CYC = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WE_HIGH_CYC =
		(T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVER_CYC =
		(T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 5;
endpackage

// file: verif/fcs_host_chk.sv
// assertions on the flash pins and user handshake of fcs_host
// assumes bind from the bench top file, one clock domain
`timescale 1ns/1ns
module fcs_host_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic [18:0] fl_addr,
	input wire logic [7:0] fl_dq_out,
	input wire logic fl_dq_oe_n,
	input wire logic fl_ce_n,
	input wire logic fl_we_n,
	input wire logic fl_oe_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_we_low;
		!fl_we_n [*5] ##1 fl_we_n;
	endsequence
	sequence s_rd_low;
		!fl_oe_n [*6] ##1 !fl_oe_n [*6] ##1 fl_oe_n;
	endsequence
	a_we_width: assert property ($fell(fl_we_n) |-> s_we_low)
		else $error("write strobe width wrong");
	// address set one cycle ahead of the strobe, so compare from next edge
	a_addr_held: assert property ($fell(fl_we_n) |=> $stable(fl_addr) [*5])
		else $error("address moved during write");
	a_data_held: assert property ($rose(fl_we_n) |-> $stable(fl_dq_out)
		&& !fl_ce_n && !fl_dq_oe_n) else $error("data released early");
	a_drive_write: assert property (!fl_we_n |-> !fl_dq_oe_n && fl_oe_n)
		else $error("write without driving data");
	a_no_contend: assert property (!fl_oe_n |-> fl_dq_oe_n && fl_we_n)
		else $error("bus contention on read");
	a_read_width: assert property ($fell(fl_oe_n) |-> s_rd_low)
		else $error("read cycle width wrong");
	a_unlock_hi: assert property (!fl_we_n && fl_addr[10:0] == 11'h2aa
		&& fl_dq_out == 8'h55 |-> fl_addr[18:11] == 8'h00)
		else $error("unlock upper address not zero");
	a_busy_quiet: assert property (!fl_ce_n |-> !cmd_ready)
		else $error("ready while flash cycle runs");
	a_rsp_once: assert property (rsp_valid |=> !rsp_valid)
		else $error("response longer than one cycle");
endmodule // fcs_host_chk

// file: verif/fcs_flash_model.sv
// behavioural byte-wide flash: command decoder, status bits, array
// assumes host pins change on ref_clk edges; busy counts status reads
`timescale 1ns/1ns
module fcs_flash_model #(parameter int BUSY = 4) (
	input wire logic ref_clk,
	input wire logic [18:0] fl_addr,
	input wire logic [7:0] fl_dq_out,
	input wire logic fl_ce_n,
	input wire logic fl_we_n,
	input wire logic fl_oe_n,
	input wire logic [7:0] prot,
	input wire logic fail_en,
	output logic [7:0] fl_dq_in
);
	localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
	localparam logic [7:0] PART = 8'h5e; // arbitrary value
	logic [7:0] mem [0:524287];
	logic [18:0] la = 19'h00000;
	logic [7:0] prog_byte = 8'h00, last = 8'h00, rd;
	logic [7:0] wd = 8'h00;
	logic we_q = 1'b1, oe_q = 1'b1, tog = 1'b0, id = 1'b0, ers = 1'b0;
	int st = 0, busy = 0;
	initial for (int i = 0; i < 524288; i++) mem[i] = 8'hff;
	always_comb begin
		if (id)
			rd = fl_addr[1:0] == 2'h0 ? MAKER : fl_addr[1:0] == 2'h1 ? PART :
				{7'h00, prot[fl_addr[18:16]]};
		else if (busy > 0)
			rd = {ers ? 1'b0 : ~prog_byte[7], tog, fail_en, 1'b0, ers,
				ers & tog, 2'h0};
		else
			rd = mem[fl_addr];
		// released bus shows a changed value, never a stale one
		fl_dq_in = (!fl_ce_n && !fl_oe_n) ? rd : ~last;
	end
	task automatic wr(input logic [18:0] a, input logic [7:0] d);
		if (busy > 0) begin
			if (d == 8'hf0 && fail_en) busy <= 0;
			return;
		end
		case (st)
		0: begin
			st <= (a[10:0] == 11'h555 && d == 8'haa) ? 1 : 0;
			if (d == 8'hf0) id <= 1'b0;
		end
		1: st <= (a[10:0] == 11'h2aa && d == 8'h55) ? 2 : 0;
		2: begin
			st <= d == 8'ha0 ? 3 : d == 8'h80 ? 4 : 0;
			if (d == 8'h90) id <= 1'b1;
		end
		3: begin
			if (!prot[a[18:16]]) mem[a] <= mem[a] & d;
			prog_byte <= d;
			ers <= 1'b0;
			busy <= BUSY;
			st <= 0;
		end
		4: st <= (a[10:0] == 11'h555 && d == 8'haa) ? 5 : 0;
		5: st <= (a[10:0] == 11'h2aa && d == 8'h55) ? 6 : 0;
		default: begin
			st <= 0;
			if (d == 8'h10 || d == 8'h30) begin
				for (int i = 0; i < 524288; i++)
					if (!prot[i[18:16]] && (d == 8'h10 || i[18:16] == a[18:16]))
						mem[i] <= 8'hff;
				ers <= 1'b1;
				busy <= BUSY;
			end
		end
		endcase
	endtask
	always @(posedge ref_clk) begin
		we_q <= fl_we_n;
		oe_q <= fl_oe_n;
		if (!fl_we_n && we_q) la <= fl_addr;
		if (fl_oe_n && !oe_q && busy > 0) begin
			tog <= ~tog;
			if (!fail_en) busy <= busy - 1;
		end
		if (!fl_oe_n && !fl_ce_n) last <= fl_dq_in;
		if (fl_we_n && !we_q && !fl_ce_n) begin
			wd <= fl_dq_out;
			wr(la, fl_dq_out);
		end
	end
endmodule // fcs_flash_model

// file: verif/fcs_host_tb.sv
// self-checking bench: fcs_host driving the behavioural flash model
// assumes fcs_host_chk and fcs_flash_model are compiled first
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
	$display("[FAIL] %0t mismatch %h %h", $time, a, b); end end
module fcs_host_tb;
	logic ref_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, fail_en = 1'b0;
	logic [2:0] cmd_op = 3'h0;
	logic [18:0] cmd_addr = 19'h00000, a, b, fl_addr;
	logic [7:0] cmd_data = 8'h00, prot = 8'h80, rd, rsp_data, fl_dq_in;
	logic [7:0] fl_dq_out;
	logic cmd_ready, rsp_valid, rsp_fail, fl_dq_oe_n, fl_ce_n, fl_we_n;
	logic fl_oe_n, fl;
	logic [7:0] sh [int];
	logic [31:0] seed = 32'd6544;
	int err_total = 0, n_compared = 0;
	fcs_host uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_fail(rsp_fail), .fl_addr(fl_addr),
		.fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n), .fl_dq_in(fl_dq_in),
		.fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n));
	fcs_flash_model mdl (.ref_clk(ref_clk), .fl_addr(fl_addr),
		.fl_dq_out(fl_dq_out), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
		.fl_oe_n(fl_oe_n), .prot(prot), .fail_en(fail_en), .fl_dq_in(fl_dq_in));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] exp_rd(input logic [18:0] x);
		return sh.exists(x) ? sh[x] : 8'hff;
	endfunction
	task automatic test_done();
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cmd(input logic [2:0] op, input logic [18:0] x,
		input logic [7:0] d);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 100) begin
			@(posedge ref_clk);
			#1 n++;
		end
		if (n >= 100) begin
			err_total++;
			test_done();
		end
		cmd_op = op;
		cmd_addr = x;
		cmd_data = d;
		cmd_valid = 1'b1;
		@(posedge ref_clk);
		#1 cmd_valid = 1'b0;
		// program and erase poll without limit, so cap the wait here
		while (rsp_valid !== 1'b1 && n < 5000) begin
			@(posedge ref_clk);
			#1 n++;
		end
		if (n >= 5000) begin
			err_total++;
			test_done();
		end
		rd = rsp_data;
		fl = rsp_fail;
	endtask
	task automatic prog(input logic [18:0] x, input logic [7:0] d);
		cmd(fcs_pkg::OP_PROGRAM, x, d);
		`CHK(fl, 1'b0)
		if (!prot[x[18:16]]) sh[x] = exp_rd(x) & d;
		`CHK(rd, exp_rd(x))
		cmd(fcs_pkg::OP_READ, x, 8'h00);
		`CHK(rd, exp_rd(x))
	endtask
	initial forever #4 ref_clk = ~ref_clk;
	initial begin
		repeat (6) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		for (int i = 0; i < 8; i++) begin
			a = 19'(rnd());
			prog(a, 8'(rnd()));
		end
		b = a ^ 19'h10000;
		prog(b, 8'h0f);
		prog(a, 8'h3c);
		prog({3'h7, a[15:0]}, 8'h00);
		cmd(fcs_pkg::OP_ID_READ, 19'h00000, 8'h00);
		`CHK(rd, mdl.MAKER)
		cmd(fcs_pkg::OP_ID_READ, 19'h00001, 8'h00);
		`CHK(rd, mdl.PART)
		cmd(fcs_pkg::OP_ID_READ, 19'h70002, 8'h00);
		`CHK(rd, 8'h01)
		cmd(fcs_pkg::OP_ID_READ, 19'h00002, 8'h00);
		`CHK(rd, 8'h00)
		cmd(fcs_pkg::OP_RESET, 19'h00000, 8'h00);
		`CHK(mdl.wd, 8'hf0)
		cmd(fcs_pkg::OP_SUSPEND, 19'h00000, 8'h00);
		`CHK(mdl.wd, 8'hb0)
		cmd(fcs_pkg::OP_RESUME, 19'h00000, 8'h00);
		`CHK(mdl.wd, 8'h30)
		cmd(fcs_pkg::OP_READ, a, 8'h00);
		`CHK(rd, exp_rd(a))
		cmd(fcs_pkg::OP_SECTOR_ERASE, a, 8'h00);
		`CHK(fl, 1'b0)
		if (!prot[a[18:16]]) sh[a] = 8'hff;
		cmd(fcs_pkg::OP_READ, a, 8'h00);
		`CHK(rd, exp_rd(a))
		cmd(fcs_pkg::OP_READ, b, 8'h00);
		`CHK(rd, exp_rd(b))
		cmd(fcs_pkg::OP_CHIP_ERASE, 19'h00100, 8'h00);
		cmd(fcs_pkg::OP_READ, b, 8'h00);
		`CHK(rd, prot[b[18:16]] ? exp_rd(b) : 8'hff)
		fail_en = 1'b1;
		cmd(fcs_pkg::OP_PROGRAM, 19'h00123, 8'h5a);
		`CHK(fl, 1'b1)
		`CHK(mdl.wd, 8'hf0)
		fail_en = 1'b0;
		cmd(fcs_pkg::OP_READ, 19'h00123, 8'h00);
		`CHK(rd, 8'h5a)
		test_done();
	end
endmodule // fcs_host_tb
bind fcs_host fcs_host_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .fl_addr(fl_addr),
	.fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n),
	.fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n));
